// ==== logic/camp_panel.sv ====
`timescale 1ns/1ns
// Operation
// - Knob variant: flare toggle routes colour black knobs; lamp lit for flare.
// - Knob inhibit on: with release up, knob rotation changes no parameter.
// - Knob inhibit off: control resumes with no step in any value.
// - Joystick variant: inhibit press with release held toggles pedestal/flare.
// - Iris display shows F-number, dashes from F16 to closed.
// - Full maps whole iris range; relative press drives lens to panel value.
// - Doubler lamp follows reported lens extender state.
// - Sensitivity knob sets iris travel span between one and two stops.
// - Range knob sets centre iris position for relative iris control.
// - Auto iris: operator offset limited to plus or minus one stop.
// - Preview pressed closes active contact, else idle contact; exactly one.
// - Preview also sent to network; configuration can suppress it.
// - Call lights far red tally; far call lights panel call lamp.
// - Joystick head press acts as preview, in parallel with switch.
// - Release held: knobs frozen; at mechanical centre offset is cleared.
// - Standard reset with release held recentres every knob control now routed; the unrouted pedestal/flare set keeps its values.
// - Head power lamp lit while head power reported on.
// - Two fiber lamps: green for good, blinking amber for warn, red for fail; attention and none both dark.
// - Cable open and short lamps show detected break or short.
// - Alarm lamp blinks on fault; alarm press while blinking requests diagnosis.
// - Camera number indicator shows the program camera number.
// - Master black level indicator shows master pedestal value.
module camp_panel #(
	parameter int DEBOUNCE_CYC = camp_pkg::DEBOUNCE_CYC,
	parameter int BLINK_CYC = camp_pkg::BLINK_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [camp_pkg::NUM_SW-1:0] sw_raw,
	input wire logic [camp_pkg::NUM_KNOBS*8-1:0] knob_pos,
	input wire logic [7:0] lens_fnum,
	input wire logic [7:0] auto_iris_setting,
	input wire logic lens_doubler_lamp_on,
	input wire logic head_power_on,
	input wire logic remote_call,
	input wire logic [2:0] fiber_head_state,
	input wire logic [2:0] fiber_base_state,
	input wire logic cable_open,
	input wire logic cable_short,
	input wire logic diag_fault,
	input wire logic [7:0] program_cam_num,
	output logic flare_lamp,
	output logic inhibit_lamp,
	output logic [7:0] iris_display,
	output logic iris_dashes,
	output logic [7:0] iris_cmd,
	output logic iris_send,
	output logic [1:0] iris_mode,
	output logic lens_doubler_lamp,
	output logic preview_active_contact,
	output logic preview_idle_contact,
	output logic net_preview,
	output logic call_tally_out,
	output logic call_lamp,
	output logic head_power_lamp,
	output logic [2:0] fiber_head_lamp,
	output logic [2:0] fiber_base_lamp,
	output logic cable_open_lamp,
	output logic cable_short_lamp,
	output logic alarm_lamp,
	output logic diag_request,
	output logic [7:0] cam_num_display,
	output logic [7:0] master_black_level
);
	// Lamp triple {red, amber, green} for one fiber direction
	function automatic logic [2:0] fiber_lamps(input logic [2:0] st, input logic blink);
		logic [2:0] l;
		l = 3'h0;
		unique case (st)
			camp_pkg::CAMP_FIB_GOOD: l = 3'h1;
			camp_pkg::CAMP_FIB_ATTN: l = 3'h0;
			camp_pkg::CAMP_FIB_WARN: l = {1'b0, blink, 1'b0};
			camp_pkg::CAMP_FIB_FAIL: l = 3'h4;
			default: l = 3'h0;
		endcase
		return l;
	endfunction : fiber_lamps

	// Saturating add of a signed step to an 8-bit value
	function automatic logic [7:0] sat_add(input logic [7:0] v, input logic signed [9:0] d);
		logic signed [10:0] s;
		s = $signed({3'h0, v}) + 11'(d);
		if (s < 0)
			return 8'h00;
		else if (s > 255)
			return 8'hff;
		return s[7:0];
	endfunction : sat_add

	////////////////////////////////////////////////////////////////////////////////
	// Switch conditioning
	logic [camp_pkg::NUM_SW-1:0] sw_db;
	logic [camp_pkg::NUM_SW-1:0] sw_prev_q;
	logic [camp_pkg::NUM_SW-1:0] press;
	logic [1:0] ctrl_q;
	logic flare_q, inhibit_q, blink_q, pv;
	logic [$clog2(BLINK_CYC+1)-1:0] blink_cnt_q;
	camp_pkg::camp_iris_mode_t mode_q;
	logic [7:0] par_q [camp_pkg::NUM_PARS];
	logic [7:0] pos_prev_q [camp_pkg::NUM_KNOBS];
	logic frozen, std_recentre;

	// Debounced so contact bounce never double-toggles a latch
	camp_debounce #(.W(camp_pkg::NUM_SW), .CNT(DEBOUNCE_CYC)) u_deb (
		.clk(clk),
		.rstn(rstn),
		.raw(sw_raw),
		.clean(sw_db)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			sw_prev_q <= '0;
		else
			sw_prev_q <= sw_db;
	end
	assign press = sw_db & ~sw_prev_q;

	// Shared blink timebase for every blinking lamp
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end else if (blink_cnt_q >= $bits(blink_cnt_q)'(BLINK_CYC - 1)) begin
			blink_cnt_q <= '0;
			blink_q <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ctrl_q <= camp_pkg::CTRL_RESET;
		else if (wr && addr == camp_pkg::ADDR_CTRL)
			ctrl_q <= wdata[1:0];
	end

	// Pedestal/flare and inhibit latches; on joystick the release chord steals the press
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flare_q <= 1'b0;
			inhibit_q <= 1'b0;
		end else begin
			if (!ctrl_q[camp_pkg::CTRL_JOY_BIT] && press[camp_pkg::SW_FLARE])
				flare_q <= ~flare_q;
			if (ctrl_q[camp_pkg::CTRL_JOY_BIT] && press[camp_pkg::SW_INHIBIT] && sw_db[camp_pkg::SW_RELEASE])
				flare_q <= ~flare_q;
			else if (press[camp_pkg::SW_INHIBIT])
				inhibit_q <= ~inhibit_q;
		end
	end

	// Iris mode selection, last press wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			mode_q <= camp_pkg::CAMP_IRIS_FULL;
		else if (press[camp_pkg::SW_AUTO])
			mode_q <= camp_pkg::CAMP_IRIS_AUTO;
		else if (press[camp_pkg::SW_REL])
			mode_q <= camp_pkg::CAMP_IRIS_REL;
		else if (press[camp_pkg::SW_FULL])
			mode_q <= camp_pkg::CAMP_IRIS_FULL;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Knob tracking by delta: parameters never jump to a knob's absolute position
	assign frozen = inhibit_q | sw_db[camp_pkg::SW_RELEASE];
	assign std_recentre = press[camp_pkg::SW_STD] & sw_db[camp_pkg::SW_RELEASE];

	for (genvar k = 0; k < camp_pkg::NUM_KNOBS; k++) begin : g_knob
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn)
				pos_prev_q[k] <= camp_pkg::KNOB_CENTER;
			else
				pos_prev_q[k] <= knob_pos[k*8 +: 8];
		end
	end

	for (genvar p = 0; p < camp_pkg::NUM_PARS; p++) begin : g_par
		localparam int KN = (p < 3) ? p : p - 3;
		logic live;
		logic signed [9:0] step;
		// Colour black knobs drive pedestal or flare set, never both
		assign live = (p < 3) ? ~flare_q : (p < 6) ? flare_q : 1'b1;
		assign step = $signed({2'b00, knob_pos[KN*8 +: 8]}) - $signed({2'b00, pos_prev_q[KN]});
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn)
				par_q[p] <= camp_pkg::KNOB_CENTER;
			else if (live && std_recentre)
				par_q[p] <= camp_pkg::KNOB_CENTER;
			else if (live && sw_db[camp_pkg::SW_RELEASE] && knob_pos[KN*8 +: 8] == camp_pkg::KNOB_CENTER)
				par_q[p] <= camp_pkg::KNOB_CENTER;
			else if (live && !frozen)
				par_q[p] <= sat_add(par_q[p], step);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Iris command: span from sensitivity, centre from range, clamp in auto
	logic [5:0] span;
	logic signed [9:0] dev;
	logic signed [16:0] rel_off;
	logic [7:0] iris_d;
	always_comb begin
		span = camp_pkg::SPAN_ONE_STOP + 6'((({1'b0, par_q[camp_pkg::PAR_IRIS_SENSITIVITY_KNOB]}) + 9'h8) >> 4);
		dev = $signed({2'b00, par_q[camp_pkg::PAR_IRIS]}) - $signed({2'b00, camp_pkg::KNOB_CENTER});
		rel_off = (17'(dev) * $signed({11'h0, span})) >>> 7;
		unique case (mode_q)
			camp_pkg::CAMP_IRIS_FULL: iris_d = par_q[camp_pkg::PAR_IRIS];
			camp_pkg::CAMP_IRIS_REL: iris_d = sat_add(par_q[camp_pkg::PAR_RANGE], rel_off[9:0]);
			default: iris_d = sat_add(auto_iris_setting, dev >>> camp_pkg::AUTO_SHIFT);
		endcase
	end

	// Send on any change, and again on a relative press to pull the lens over
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			iris_cmd <= camp_pkg::KNOB_CENTER;
			iris_send <= 1'b0;
		end else begin
			iris_cmd <= iris_d;
			iris_send <= (iris_d != iris_cmd) | press[camp_pkg::SW_REL];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Preview contacts and network preview
	assign pv = sw_db[camp_pkg::SW_PREVIEW] | (ctrl_q[camp_pkg::CTRL_JOY_BIT] & sw_db[camp_pkg::SW_JOY]);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			preview_active_contact <= 1'b0;
			preview_idle_contact <= 1'b1;
			net_preview <= 1'b0;
		end else begin
			preview_active_contact <= pv;
			preview_idle_contact <= ~pv;
			net_preview <= pv & ctrl_q[camp_pkg::CTRL_NETPV_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lamps and indicators, registered so outputs never glitch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flare_lamp <= 1'b0;
			inhibit_lamp <= 1'b0;
			iris_display <= 8'h00;
			iris_dashes <= 1'b0;
			iris_mode <= 2'h0;
			lens_doubler_lamp <= 1'b0;
			call_tally_out <= 1'b0;
			call_lamp <= 1'b0;
			head_power_lamp <= 1'b0;
			fiber_head_lamp <= 3'h0;
			fiber_base_lamp <= 3'h0;
			cable_open_lamp <= 1'b0;
			cable_short_lamp <= 1'b0;
			alarm_lamp <= 1'b0;
			diag_request <= 1'b0;
			cam_num_display <= 8'h00;
			master_black_level <= camp_pkg::KNOB_CENTER;
		end else begin
			flare_lamp <= flare_q;
			inhibit_lamp <= inhibit_q;
			iris_dashes <= lens_fnum >= camp_pkg::FNUM_F16;
			iris_display <= (lens_fnum >= camp_pkg::FNUM_F16) ? 8'h00 : lens_fnum;
			iris_mode <= mode_q;
			lens_doubler_lamp <= lens_doubler_lamp_on;
			call_tally_out <= sw_db[camp_pkg::SW_CALL];
			call_lamp <= remote_call;
			head_power_lamp <= head_power_on;
			fiber_head_lamp <= fiber_lamps(fiber_head_state, blink_q);
			fiber_base_lamp <= fiber_lamps(fiber_base_state, blink_q);
			cable_open_lamp <= cable_open;
			cable_short_lamp <= cable_short;
			alarm_lamp <= diag_fault & blink_q;
			diag_request <= press[camp_pkg::SW_ALARM] & diag_fault;
			cam_num_display <= program_cam_num;
			master_black_level <= par_q[camp_pkg::PAR_MPED];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read, data in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			if (addr == camp_pkg::ADDR_CTRL)
				rdata <= {6'h0, ctrl_q};
			else if (addr == camp_pkg::ADDR_PANEL)
				rdata <= {1'b0, diag_fault, pv, mode_q, sw_db[camp_pkg::SW_RELEASE], inhibit_q, flare_q};
			else if (addr == camp_pkg::ADDR_IRIS_CMD)
				rdata <= iris_cmd;
			else if (addr >= camp_pkg::ADDR_PAR_BASE && addr <= camp_pkg::ADDR_PAR_LAST)
				rdata <= par_q[4'(addr - camp_pkg::ADDR_PAR_BASE)];
			else
				rdata <= 8'h00;
		end else begin
			rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_pv_exclusive;
		@(posedge clk) disable iff (!rstn) preview_active_contact != preview_idle_contact;
	endproperty
	a_pv_exclusive: assert property (p_pv_exclusive) else $error("preview contacts not exclusive");

	property p_pv_follow;
		@(posedge clk) disable iff (!rstn) pv |=> preview_active_contact;
	endproperty
	a_pv_follow: assert property (p_pv_follow) else $error("preview contact late");

	property p_inhibit_hold;
		@(posedge clk) disable iff (!rstn)
			$past(inhibit_q) && !$past(sw_db[camp_pkg::SW_RELEASE]) |-> $stable(par_q[camp_pkg::PAR_MPED]);
	endproperty
	a_inhibit_hold: assert property (p_inhibit_hold) else $error("knob moved value while inhibited");

	property p_flare_lamp;
		@(posedge clk) disable iff (!rstn)
			!ctrl_q[camp_pkg::CTRL_JOY_BIT] && press[camp_pkg::SW_FLARE] |=> ##1 flare_lamp != $past(flare_lamp);
	endproperty
	a_flare_lamp: assert property (p_flare_lamp) else $error("flare lamp mismatch");

	property p_dashes;
		@(posedge clk) disable iff (!rstn) lens_fnum >= camp_pkg::FNUM_F16 |=> iris_dashes && iris_display == 8'h00;
	endproperty
	a_dashes: assert property (p_dashes) else $error("dashes missing at F16 or closed");

	property p_doubler;
		@(posedge clk) disable iff (!rstn) lens_doubler_lamp_on[*2] |-> ##0 lens_doubler_lamp;
	endproperty
	a_doubler: assert property (p_doubler) else $error("doubler lamp dark");

	property p_net_pv;
		@(posedge clk) disable iff (!rstn) !ctrl_q[camp_pkg::CTRL_NETPV_BIT] |=> !net_preview;
	endproperty
	a_net_pv: assert property (p_net_pv) else $error("network preview not suppressed");

	property p_auto_limit;
		@(posedge clk) disable iff (!rstn)
			mode_q == camp_pkg::CAMP_IRIS_AUTO && auto_iris_setting == 8'h80 |-> iris_d >= 8'h70 && iris_d <= 8'h8f;
	endproperty
	a_auto_limit: assert property (p_auto_limit) else $error("auto iris offset beyond one stop");

	property p_alarm_dark;
		@(posedge clk) disable iff (!rstn) !diag_fault |=> !alarm_lamp;
	endproperty
	a_alarm_dark: assert property (p_alarm_dark) else $error("alarm lamp without fault");

	property p_call;
		@(posedge clk) disable iff (!rstn) remote_call |=> call_lamp;
	endproperty
	a_call: assert property (p_call) else $error("call lamp dark on far call");
endmodule : camp_panel

// ==== logic/camp_pkg.sv ====
package camp_pkg;
	// Base clock and time figures
	localparam int CLK_HZ = 20_000_000;
	localparam int DEBOUNCE_MS = 5;
	localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, 4-bit word address, 8-bit data
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_PANEL = 4'h1;
	localparam logic [3:0] ADDR_IRIS_CMD = 4'h2;
	localparam logic [3:0] ADDR_PAR_BASE = 4'h4;
	localparam logic [3:0] ADDR_PAR_LAST = 4'hd;
	localparam int CTRL_JOY_BIT = 0;
	localparam int CTRL_NETPV_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Switch inputs
	localparam int SW_FLARE = 0;
	localparam int SW_INHIBIT = 1;
	localparam int SW_RELEASE = 2;
	localparam int SW_STD = 3;
	localparam int SW_FULL = 4;
	localparam int SW_REL = 5;
	localparam int SW_AUTO = 6;
	localparam int SW_PREVIEW = 7;
	localparam int SW_JOY = 8;
	localparam int SW_CALL = 9;
	localparam int SW_ALARM = 10;
	localparam int NUM_SW = 11;

	////////////////////////////////////////////////////////////////////////////////
	// Knobs: 0..2 colour black, 3 master black, 4 iris, 5 range, 6 sensitivity
	localparam int NUM_KNOBS = 7;
	localparam int KN_MPED = 3;
	localparam int KN_IRIS = 4;
	// Parameters: 0..2 pedestal, 3..5 flare, 6 master, 7 iris, 8 range, 9 iris_sensitivity_knob
	localparam int NUM_PARS = 10;
	localparam int PAR_MPED = 6;
	localparam int PAR_IRIS = 7;
	localparam int PAR_RANGE = 8;
	localparam int PAR_IRIS_SENSITIVITY_KNOB = 9;
	localparam logic [7:0] KNOB_CENTER = 8'h80;

	// Iris scale: 1/16 stop per step
	localparam logic [5:0] SPAN_ONE_STOP = 6'h10;
	localparam int AUTO_SHIFT = 3;
	localparam logic [7:0] FNUM_F16 = 8'ha0;

	typedef enum logic [1:0] {
		CAMP_IRIS_FULL = 2'b00,
		CAMP_IRIS_REL = 2'b01,
		CAMP_IRIS_AUTO = 2'b10
	} camp_iris_mode_t;

	typedef enum logic [2:0] {
		CAMP_FIB_GOOD = 3'b000,
		CAMP_FIB_ATTN = 3'b001,
		CAMP_FIB_WARN = 3'b010,
		CAMP_FIB_FAIL = 3'b011,
		CAMP_FIB_NONE = 3'b100
	} camp_fiber_t;
endpackage : camp_pkg

// ==== logic/camp_debounce.sv ====
`timescale 1ns/1ns
module camp_debounce #(
	parameter int W = 1,
	parameter int CNT = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] raw,
	output logic [W-1:0] clean
);
	////////////////////////////////////////////////////////////////////////////////
	// One settle counter per switch; a level must hold CNT cycles to be taken
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic [$clog2(CNT+1)-1:0] cnt_q;
		logic clean_q;
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				cnt_q <= '0;
				clean_q <= 1'b0;
			end else if (raw[i] == clean_q) begin
				cnt_q <= '0;
			end else if (cnt_q >= $bits(cnt_q)'(CNT - 1)) begin
				cnt_q <= '0;
				clean_q <= raw[i];
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
		assign clean[i] = clean_q;
	end
endmodule : camp_debounce

// ==== bench/camp_far_model.sv ====
`timescale 1ns/1ns
// Far end of the command link: base station and camera head status
module camp_far_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic call_tally_out,
	input wire logic [7:0] iris_cmd,
	input wire logic iris_send,
	output logic [7:0] lens_fnum,
	output logic [7:0] auto_iris_setting,
	output logic lens_doubler_lamp_on,
	output logic head_power_on,
	output logic remote_call,
	output logic [2:0] fiber_head_state,
	output logic [2:0] fiber_base_state,
	output logic cable_open,
	output logic cable_short,
	output logic diag_fault,
	output logic [7:0] program_cam_num
);
	logic red_tally_q;
	logic [7:0] lens_iris_q;
	int sends;

	// Quiet link at start; the bench changes these at clock edges
	initial begin
		lens_fnum = 8'h28;
		auto_iris_setting = 8'h40;
		{lens_doubler_lamp_on, head_power_on, remote_call, cable_open, cable_short, diag_fault} = 6'h00;
		fiber_head_state = 3'h4;
		fiber_base_state = 3'h4;
		program_cam_num = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Red tally at head and base follows the panel call
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			red_tally_q <= 1'b0;
		end else begin
			red_tally_q <= call_tally_out;
		end
	end

	// Lens servo takes each command; only a send moves the iris
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lens_iris_q <= 8'h80;
			sends <= 0;
		end else if (iris_send) begin
			lens_iris_q <= iris_cmd;
			sends <= sends + 1;
		end
	end
endmodule : camp_far_model

// ==== bench/camp_panel_tb_top.sv ====
`timescale 1ns/1ns
module camp_panel_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [10:0] sw_raw = 11'h000;
	logic [55:0] knob_pos = {7{8'h80}};
	logic [7:0] rdata, iris_display, iris_cmd, cam_num_display, master_black_level;
	logic [7:0] lens_fnum, auto_iris_setting, program_cam_num, d, o, a;
	logic [2:0] fiber_head_lamp, fiber_base_lamp, fiber_head_state, fiber_base_state;
	logic [1:0] iris_mode;
	logic flare_lamp, inhibit_lamp, iris_dashes, iris_send, lens_doubler_lamp, call_tally_out, call_lamp;
	logic preview_active_contact, preview_idle_contact, net_preview, head_power_lamp, alarm_lamp;
	logic cable_open_lamp, cable_short_lamp, diag_request, lens_doubler_lamp_on, head_power_on, remote_call;
	logic cable_open, cable_short, diag_fault;
	int errors = 0;
	int num_checks = 0;

	// 20 MHz clock
	always #25 clk = ~clk;

	// Short debounce and blink counts keep the run brief
	camp_panel #(.DEBOUNCE_CYC(4), .BLINK_CYC(8)) u_camp_panel (.*);
	camp_far_model u_camp_far_model (.*);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Ends one nanosecond past an edge so sampling is settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wreg(input logic [3:0] ad, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= ad;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	// Read data stand only in the cycle after the strobe
	task automatic rreg(input logic [3:0] ad, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= ad;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rreg

	task automatic sw(input int b, input logic v);
		@(posedge clk);
		sw_raw[b] <= v;
		cyc(12);
	endtask : sw

	task automatic press(input int b);
		sw(b, 1'b1);
		sw(b, 1'b0);
	endtask : press

	task automatic knob(input int k, input logic [7:0] v);
		@(posedge clk);
		knob_pos[k*8+:8] <= v;
		cyc(4);
	endtask : knob

	// Or and and of the blinking lamps over a span, to see both phases
	task automatic watch(input int n);
		o = 8'h00;
		a = 8'hff;
		repeat (n) begin
			@(posedge clk);
			#1 o = o | {diag_request, alarm_lamp, fiber_base_lamp, fiber_head_lamp};
			a = a & {diag_request, alarm_lamp, fiber_base_lamp, fiber_head_lamp};
		end
	endtask : watch

	task automatic done(input string n);
		$display("Test %s finished, checks %0d", n, num_checks);
	endtask : done

	task automatic final_report;
		$display("Checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("idle", 8'(preview_idle_contact), 8'h01);
		chk("active", 8'(preview_active_contact), 8'h00);
		chk("mbl", master_black_level, 8'h80);
		rreg(camp_pkg::ADDR_CTRL, d);
		chk("ctrl", d, 8'h02);
		cyc(1);
		chk("rdata idle", rdata, 8'h00);
		wreg(camp_pkg::ADDR_PANEL, 8'hff);
		rreg(camp_pkg::ADDR_PANEL, d);
		chk("panel ro", d, 8'h00);
		rreg(4'hf, d);
		chk("unmapped", d, 8'h00);
		done("reset");
	endtask : t_reset

	// Status lamps and displays follow the link; doubler, head power and short lamps in both polarities
	task automatic t_link;
		@(posedge clk);
		u_camp_far_model.lens_doubler_lamp_on <= 1'b1;
		u_camp_far_model.head_power_on <= 1'b1;
		u_camp_far_model.cable_open <= 1'b1;
		u_camp_far_model.program_cam_num <= 8'h2a;
		u_camp_far_model.lens_fnum <= 8'h9f;
		cyc(3);
		chk("doubler", 8'(lens_doubler_lamp), 8'h01);
		chk("headpwr", 8'(head_power_lamp), 8'h01);
		chk("open", 8'(cable_open_lamp), 8'h01);
		chk("short", 8'(cable_short_lamp), 8'h00);
		chk("camnum", cam_num_display, 8'h2a);
		chk("fnum", iris_display, 8'h9f);
		chk("dash", 8'(iris_dashes), 8'h00);
		@(posedge clk);
		u_camp_far_model.lens_doubler_lamp_on <= 1'b0;
		u_camp_far_model.head_power_on <= 1'b0;
		u_camp_far_model.cable_short <= 1'b1;
		u_camp_far_model.lens_fnum <= camp_pkg::FNUM_F16;
		cyc(3);
		chk("doubler", 8'(lens_doubler_lamp), 8'h00);
		chk("headpwr", 8'(head_power_lamp), 8'h00);
		chk("short", 8'(cable_short_lamp), 8'h01);
		chk("dash", {iris_display[6:0], iris_dashes}, 8'h01);
		done("link");
	endtask : t_link

	task automatic pv(input int b, input logic [7:0] c, input logic n);
		wreg(camp_pkg::ADDR_CTRL, c);
		sw(b, 1'b1);
		chk("pv on", {net_preview, preview_active_contact, preview_idle_contact}, {n, 2'b10});
		sw(b, 1'b0);
		chk("pv off", {net_preview, preview_active_contact, preview_idle_contact}, 8'h01);
	endtask : pv

	task automatic t_call;
		sw(camp_pkg::SW_CALL, 1'b1);
		chk("tally", {call_tally_out, u_camp_far_model.red_tally_q}, 8'h03);
		sw(camp_pkg::SW_CALL, 1'b0);
		@(posedge clk);
		u_camp_far_model.remote_call <= 1'b1;
		cyc(3);
		chk("call lamp", 8'(call_lamp), 8'h01);
		done("call");
	endtask : t_call

	// Inhibit, release and standard reset on the master black knob
	task automatic t_knobs;
		wreg(camp_pkg::ADDR_CTRL, 8'h00);
		knob(camp_pkg::KN_MPED, 8'h90);
		chk("mbl", master_black_level, 8'h90);
		press(camp_pkg::SW_INHIBIT);
		chk("inh lamp", 8'(inhibit_lamp), 8'h01);
		knob(camp_pkg::KN_MPED, 8'ha0);
		chk("mbl inh", master_black_level, 8'h90);
		press(camp_pkg::SW_INHIBIT);
		chk("mbl resume", master_black_level, 8'h90);
		knob(camp_pkg::KN_MPED, 8'ha8);
		rreg(4'(camp_pkg::ADDR_PAR_BASE + camp_pkg::PAR_MPED), d);
		chk("par mped", d, 8'h98);
		sw(camp_pkg::SW_RELEASE, 1'b1);
		knob(camp_pkg::KN_MPED, 8'hb8);
		chk("mbl free", master_black_level, 8'h98);
		knob(camp_pkg::KN_MPED, 8'h80);
		chk("mbl centre", master_black_level, 8'h80);
		sw(camp_pkg::SW_RELEASE, 1'b0);
		knob(camp_pkg::KN_MPED, 8'h90);
		sw(camp_pkg::SW_RELEASE, 1'b1);
		press(camp_pkg::SW_STD);
		chk("mbl std", master_black_level, 8'h80);
		sw(camp_pkg::SW_RELEASE, 1'b0);
		done("knobs");
	endtask : t_knobs

	task automatic t_flare;
		press(camp_pkg::SW_FLARE);
		chk("flare", 8'(flare_lamp), 8'h01);
		knob(0, 8'h90);
		rreg(4'(camp_pkg::ADDR_PAR_BASE + 3), d);
		chk("flare r", d, 8'h90);
		rreg(camp_pkg::ADDR_PAR_BASE, d);
		chk("ped r", d, 8'h80);
		press(camp_pkg::SW_FLARE);
		chk("flare", 8'(flare_lamp), 8'h00);
		// Joystick variant ignores the flare switch
		wreg(camp_pkg::ADDR_CTRL, 8'h01);
		press(camp_pkg::SW_FLARE);
		chk("flare joy", 8'(flare_lamp), 8'h00);
		sw(camp_pkg::SW_RELEASE, 1'b1);
		press(camp_pkg::SW_INHIBIT);
		chk("joy toggle", {inhibit_lamp, flare_lamp}, 8'h01);
		sw(camp_pkg::SW_RELEASE, 1'b0);
		done("flare");
	endtask : t_flare

	// Iris knob 0x40 above centre; range and iris_sensitivity_knob start at 0x80
	task automatic t_iris;
		int s0;
		press(camp_pkg::SW_AUTO);
		knob(camp_pkg::KN_IRIS, 8'hc0);
		chk("auto", {iris_mode, iris_cmd}, {2'h2, 8'h48});
		knob(camp_pkg::KN_IRIS, 8'hff);
		chk("auto max", iris_cmd, 8'h4f);
		knob(camp_pkg::KN_IRIS, 8'hc0);
		press(camp_pkg::SW_FULL);
		chk("full", {iris_mode, iris_cmd}, {2'h0, 8'hc0});
		s0 = u_camp_far_model.sends;
		press(camp_pkg::SW_REL);
		chk("rel", {iris_mode, iris_cmd}, {2'h1, 8'h8c});
		chk("lens", u_camp_far_model.lens_iris_q, 8'h8c);
		// One send for the press itself, one for the new value
		chk("sends", 16'(u_camp_far_model.sends - s0), 16'h0002);
		knob(5, 8'h90);
		chk("range", iris_cmd, 8'h9c);
		knob(6, 8'h00);
		chk("iris_sensitivity_knob", iris_cmd, 8'h98);
		done("iris");
	endtask : t_iris

	task automatic t_lamps;
		logic [2:0] eo[5] = '{3'h1, 3'h0, 3'h2, 3'h4, 3'h0};
		logic [2:0] ea[5] = '{3'h1, 3'h0, 3'h0, 3'h4, 3'h0};
		for (int s = 0; s < 5; s++) begin
			@(posedge clk);
			u_camp_far_model.fiber_head_state <= 3'(s);
			u_camp_far_model.fiber_base_state <= 3'(s);
			cyc(3);
			watch(24);
			chk("fiber or", {2'h0, o[5:0]}, {2'h0, eo[s], eo[s]});
			chk("fiber and", {2'h0, a[5:0]}, {2'h0, ea[s], ea[s]});
		end
		@(posedge clk);
		u_camp_far_model.diag_fault <= 1'b1;
		cyc(3);
		watch(24);
		chk("alarm blink", {o[6], a[6]}, 8'h02);
		@(posedge clk);
		sw_raw[camp_pkg::SW_ALARM] <= 1'b1;
		watch(16);
		chk("diag req", 8'(o[7]), 8'h01);
		sw(camp_pkg::SW_ALARM, 1'b0);
		@(posedge clk);
		u_camp_far_model.diag_fault <= 1'b0;
		cyc(3);
		watch(24);
		chk("alarm off", 8'(o[6]), 8'h00);
		done("lamps");
	endtask : t_lamps

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence after 16 reset cycles
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		cyc(2);
		t_reset();
		t_link();
		pv(camp_pkg::SW_PREVIEW, 8'h02, 1'b1);
		pv(camp_pkg::SW_PREVIEW, 8'h00, 1'b0);
		pv(camp_pkg::SW_JOY, 8'h03, 1'b1);
		done("preview");
		t_call();
		t_knobs();
		t_flare();
		t_iris();
		t_lamps();
		final_report();
	end

	// Tests need under a thousand cycles; far more means a hang
	initial begin
		#(50 * 20000);
		errors++;
		final_report();
	end
endmodule : camp_panel_tb_top
